// ### rtl/mct_pkg.sv
// Package of constants for the motor constant tuning sequencer
package mct_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_TUNE   = 8'h04;
  localparam logic [7:0] OFS_MOTOR  = 8'h08;
  localparam logic [7:0] OFS_STAT   = 8'h0c;
  localparam logic [7:0] OFS_ISTAT  = 8'h10;
  localparam logic [7:0] OFS_IMASK  = 8'h14;
  localparam logic [7:0] OFS_MON    = 8'h18;
  localparam logic [7:0] OFS_FAULT  = 8'h1c;
  // ==========================================================
  // Control register fields
  localparam int CTRL_VECT_BIT  = 0;
  localparam int CTRL_PANEL_BIT = 1;
  localparam int CTRL_MONSEL_LO = 2;
  localparam logic [1:0] MONSEL_SPEED = 2'h0;
  localparam logic [1:0] MONSEL_FREQ  = 2'h1;
  localparam logic [1:0] MONSEL_CURR  = 2'h2;
  // ==========================================================
  // Tuning setting / status codes
  localparam logic [7:0] TS_OFF       = 8'h00;
  localparam logic [7:0] TS_ALL       = 8'h01;
  localparam logic [7:0] TS_ALL_RUN   = 8'h02;
  localparam logic [7:0] TS_ALL_DONE  = 8'h03;
  localparam logic [7:0] TS_FORCED    = 8'h08;
  localparam logic [7:0] TS_PROT      = 8'h09;
  localparam logic [7:0] TS_R_ONLY    = 8'h0b;
  localparam logic [7:0] TS_R_RUN     = 8'h0c;
  localparam logic [7:0] TS_R_DONE    = 8'h0d;
  localparam logic [7:0] TS_STALL     = 8'h5b;
  localparam logic [7:0] TS_VOLT      = 8'h5c;
  localparam logic [7:0] TS_CALC      = 8'h5d;
  // Unset code of capacity and pole count
  localparam logic [15:0] PARAM_UNSET = 16'h270f;
  // Highest operating frequency in Hz
  localparam logic [7:0] MAX_FREQ_HZ  = 8'h78;
  // ==========================================================
  // Timing: seconds as printed, converted at 100 MHz
  localparam longint CLK_HZ       = 100000000;
  localparam longint T_ALL_S      = 25;
  localparam longint T_R_S        = 9;
  localparam longint CYC_ALL      = T_ALL_S * CLK_HZ;
  localparam longint CYC_R        = T_R_S * CLK_HZ;
  // Interrupt status bits
  localparam int IRQ_START = 0;
  localparam int IRQ_DONE  = 1;
  localparam int IRQ_ERR   = 2;
  localparam int IRQ_CLEAR = 3;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_END} mct_state_t;
endpackage

// ### rtl/mct_sequencer.sv
// Motor constant tuning sequencer with an AHB-Lite register slave
// Operation
// - Tuning allowed only with capacity and poles set and vector control chosen.
// - Tuning also allowed under V/F when the V/F switch input selects it.
// - Setting 1 measures all constants, standstill, about 25 to 75 s.
// - Setting 11 measures stator resistance only, about 9 s.
// - Output stop, reset, panel stop, or start release aborts tuning.
// - During tuning only stop, reset, start inputs and run, monitor, alarm act.
// - Speed or frequency monitor selection shows tuning progress instead.
// - Running output asserts as soon as tuning begins.
// - Status codes: 2/12 measuring, 3/13 done, 9 protective error.
// - Set-frequency monitor reads zero while tuning.
// - No new operation until cleared; then monitor returns to normal.
// - Tuning supports operating frequencies up to 120 Hz.
// - On error the motor constants stay unchanged; reset and retune.
// - Error codes 8 forced, 91 stall, 92 voltage, 93 calculation or no motor.
module mct_sequencer
  import mct_pkg::*;
#(
  parameter longint ALL_CYCLES = CYC_ALL,
  parameter longint R_CYCLES   = CYC_R
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Terminal inputs
  input  wire logic        forward_start_input,
  input  wire logic        reverse_start_input,
  input  wire logic        output_stop_input,
  input  wire logic        drive_reset_input,
  input  wire logic        vf_switch_input,
  input  wire logic        second_function_select_input,
  input  wire logic        panel_run_key,
  input  wire logic        panel_stop_key,
  // Status from the measurement engine
  input  wire logic        prot_fault,
  input  wire logic        stall_fault,
  input  wire logic        volt_fault,
  input  wire logic        calc_fault,
  input  wire logic [7:0]  speed_monitor,
  input  wire logic [7:0]  current_monitor,
  // Outputs
  output logic             running_output,
  output logic [7:0]       analog_monitor_output,
  output logic [7:0]       set_freq_monitor,
  output logic             measure_full,
  output logic             measure_r_only,
  output logic             constants_write_en,
  output logic             inputs_gated,
  output logic             irq
);
  // ==========================================================
  // Input synchronisers
  localparam int NIN = 12;
  logic [NIN-1:0] sync1_ff, sync2_ff;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else if (clk_en) begin
      sync1_ff <= {calc_fault, volt_fault, stall_fault, prot_fault, panel_stop_key, panel_run_key,
                   second_function_select_input, vf_switch_input, drive_reset_input,
                   output_stop_input, reverse_start_input, forward_start_input};
      sync2_ff <= sync1_ff;
    end
  end
  logic s_fwd, s_rev, s_mrs, s_rst, s_vf, s_run, s_stp, s_prot, s_stall, s_volt, s_calc;
  assign s_fwd   = sync2_ff[0];
  assign s_rev   = sync2_ff[1];
  assign s_mrs   = sync2_ff[2];
  assign s_rst   = sync2_ff[3];
  assign s_vf    = sync2_ff[4];
  assign s_run   = sync2_ff[6];
  assign s_stp   = sync2_ff[7];
  assign s_prot  = sync2_ff[8];
  assign s_stall = sync2_ff[9];
  assign s_volt  = sync2_ff[10];
  assign s_calc  = sync2_ff[11];

  // ==========================================================
  // Register state
  logic [3:0]  ctrl_ff, nxt_ctrl;
  logic [7:0]  tune_ff, nxt_tune;
  logic [15:0] cap_ff, nxt_cap, pole_ff, nxt_pole;
  logic [3:0]  istat_ff, nxt_istat, imask_ff, nxt_imask;
  logic [7:0]  freq_set_ff, nxt_freq_set;
  mct_state_t  st_ff, nxt_st;
  logic [31:0] cnt_ff, nxt_cnt;
  logic        rd_ready_ff, nxt_rd_ready;
  logic        launched_ext_ff, nxt_launched_ext;
  logic        ap_wr_ff, ap_rd_ff;
  logic [7:0]  ap_addr_ff;
  logic [31:0] rdata_ff, nxt_rdata;

  // AHB address phase capture
  logic ap_valid;
  assign ap_valid = hsel && hready && htrans[1];
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ap_wr_ff   <= 1'b0;
      ap_rd_ff   <= 1'b0;
      ap_addr_ff <= 8'h00;
    end else if (clk_en && hready) begin
      // A stalled read keeps its own phase until the wait state is over
      ap_wr_ff   <= ap_valid && hwrite;
      ap_rd_ff   <= ap_valid && !hwrite;
      ap_addr_ff <= haddr[7:0];
    end
  end
  // Reads take one wait state so hrdata comes from a flip-flop in the data phase;
  // writes take none. One cycle per read is traded for a registered read path.
  logic rd_load;
  assign rd_load   = ap_rd_ff && !rd_ready_ff;
  assign hreadyout = !rd_load;
  // Response is always OKAY
  assign hresp     = 1'b0;
  assign hrdata    = rdata_ff;

  // Run length of a setting; both lengths are parameters so a bench can shorten them
  function automatic logic [31:0] cycles_for(input logic [7:0] ts);
    cycles_for = (ts == TS_ALL) ? 32'(ALL_CYCLES) : 32'(R_CYCLES);
  endfunction

  // ==========================================================
  // Sequencer and register next state
  logic start_any, abort, permitted, clear_req, err_any;
  logic [7:0] err_code;
  logic [31:0] total;
  always_comb begin
    nxt_ctrl         = ctrl_ff;
    nxt_tune         = tune_ff;
    nxt_cap          = cap_ff;
    nxt_pole         = pole_ff;
    nxt_imask        = imask_ff;
    nxt_freq_set     = freq_set_ff;
    nxt_st           = st_ff;
    nxt_cnt          = cnt_ff;
    nxt_launched_ext = launched_ext_ff;
    nxt_istat        = istat_ff;
    nxt_rdata        = 32'h0;
    start_any        = s_fwd || s_rev;
    nxt_rd_ready     = rd_load;
    // Capacity and poles set plus vector control, or V/F by switch
    // permission check
    permitted = ((cap_ff != PARAM_UNSET) && (pole_ff != PARAM_UNSET) && ctrl_ff[CTRL_VECT_BIT])
                || s_vf;
    abort = s_mrs || s_rst || s_stp || (launched_ext_ff && !start_any);
    // clearing action
    // Level test: a start input already dropped by an abort must still clear
    clear_req = ctrl_ff[CTRL_PANEL_BIT] ? s_stp : !start_any;
    err_any = s_prot || s_stall || s_volt || s_calc;
    err_code = s_prot ? TS_PROT : s_stall ? TS_STALL : s_volt ? TS_VOLT : TS_CALC;
    total = cycles_for(tune_ff == TS_ALL_RUN ? TS_ALL : TS_R_ONLY);
    // A read of the interrupt status register clears it afterwards
    if (rd_load) begin
      unique case (ap_addr_ff)
        OFS_CTRL:  nxt_rdata = {28'h0, ctrl_ff};
        OFS_TUNE:  nxt_rdata = {24'h0, tune_ff};
        OFS_MOTOR: nxt_rdata = {pole_ff, cap_ff};
        OFS_STAT:  nxt_rdata = {28'h0, permitted, running_output, 2'(st_ff)};
        OFS_ISTAT: nxt_rdata = {28'h0, istat_ff};
        OFS_IMASK: nxt_rdata = {28'h0, imask_ff};
        OFS_MON:   nxt_rdata = {24'h0, freq_set_ff};
        default:   nxt_rdata = 32'h0;
      endcase
    end
    // Clear comes before the event sets below, so an event in the same cycle wins
    if (rd_load && ap_addr_ff == OFS_ISTAT) nxt_istat = 4'h0;
    if (ap_wr_ff) begin
      unique case (ap_addr_ff)
        OFS_CTRL:  nxt_ctrl = hwdata[3:0];
        // Setting change only accepted while idle
        OFS_TUNE:  if (st_ff == ST_IDLE) nxt_tune = hwdata[7:0];
        OFS_MOTOR: if (st_ff == ST_IDLE) begin
          nxt_cap  = hwdata[15:0];
          nxt_pole = hwdata[31:16];
        end
        OFS_IMASK: nxt_imask = hwdata[3:0];
        OFS_MON:   nxt_freq_set = (hwdata[7:0] > MAX_FREQ_HZ) ? MAX_FREQ_HZ : hwdata[7:0];
        default:   ;
      endcase
    end
    unique case (st_ff)
      ST_IDLE: begin
        // launch on start or run key
        if (permitted && (tune_ff == TS_ALL || tune_ff == TS_R_ONLY) &&
            ((ctrl_ff[CTRL_PANEL_BIT] && s_run) || (!ctrl_ff[CTRL_PANEL_BIT] && start_any))) begin
          nxt_st           = ST_RUN;
          nxt_tune         = (tune_ff == TS_ALL) ? TS_ALL_RUN : TS_R_RUN;
          nxt_cnt          = 32'h0;
          nxt_launched_ext = !ctrl_ff[CTRL_PANEL_BIT];
          nxt_istat[IRQ_START] = 1'b1;
        end
      end
      ST_RUN: begin
        // Abort is tested first so a stop during a fault reports a forced end
        if (abort) begin
          nxt_st = ST_END;
          nxt_tune = TS_FORCED;
          nxt_istat[IRQ_ERR] = 1'b1;
        end else if (err_any) begin
          nxt_st = ST_END;
          nxt_tune = err_code;
          nxt_istat[IRQ_ERR] = 1'b1;
        end else if (cnt_ff + 32'h1 >= total) begin
          nxt_st = ST_END;
          nxt_tune = (tune_ff == TS_ALL_RUN) ? TS_ALL_DONE : TS_R_DONE;
          nxt_istat[IRQ_DONE] = 1'b1;
        end else begin
          nxt_cnt = cnt_ff + 32'h1;
        end
      end
      ST_END: begin
        if (clear_req) begin
          nxt_st = ST_IDLE;
          nxt_launched_ext = 1'b0;
          nxt_istat[IRQ_CLEAR] = 1'b1;
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_ff         <= 4'h0;
      tune_ff         <= TS_OFF;
      cap_ff          <= PARAM_UNSET;
      pole_ff         <= PARAM_UNSET;
      istat_ff        <= 4'h0;
      imask_ff        <= 4'h0;
      freq_set_ff     <= 8'h00;
      st_ff           <= ST_IDLE;
      cnt_ff          <= 32'h0;
      rd_ready_ff     <= 1'b0;
      launched_ext_ff <= 1'b0;
      rdata_ff        <= 32'h0;
    end else if (clk_en) begin
      ctrl_ff         <= nxt_ctrl;
      tune_ff         <= nxt_tune;
      cap_ff          <= nxt_cap;
      pole_ff         <= nxt_pole;
      istat_ff        <= nxt_istat;
      imask_ff        <= nxt_imask;
      freq_set_ff     <= nxt_freq_set;
      st_ff           <= nxt_st;
      cnt_ff          <= nxt_cnt;
      rd_ready_ff     <= nxt_rd_ready;
      launched_ext_ff <= nxt_launched_ext;
      rdata_ff        <= nxt_rdata;
    end
  end

  // ==========================================================
  // Outputs
  logic [7:0] progress;
  logic tuning;
  always_comb begin
    tuning   = (st_ff == ST_RUN);
    // Progress scaled to 0..255; divide is small cost at 40 bits
    progress = (total == 32'h0) ? 8'h00 : 8'(({cnt_ff, 8'h00}) / {8'h00, total});
  end
  assign running_output = tuning;
  assign inputs_gated   = tuning;
  assign measure_full   = tuning && (tune_ff == TS_ALL_RUN);
  assign measure_r_only = tuning && (tune_ff == TS_R_RUN);
  // Constants written only on a normal end
  assign constants_write_en = (st_ff == ST_END) && (tune_ff == TS_ALL_DONE || tune_ff == TS_R_DONE);
  assign analog_monitor_output = (tuning && (ctrl_ff[3:2] == MONSEL_SPEED || ctrl_ff[3:2] == MONSEL_FREQ))
                                 ? progress
                                 : (ctrl_ff[3:2] == MONSEL_CURR ? current_monitor : speed_monitor);
  assign set_freq_monitor = (st_ff != ST_IDLE) ? 8'h00 : freq_set_ff;
  // Level interrupt; software drops it by reading the interrupt status register
  assign irq = |(istat_ff & imask_ff);
endmodule

// ### dv/mct_sequencer_monitor.sv
// Checker of the tuning sequencer terminal behaviour
module mct_sequencer_monitor (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst,
  // Terminal inputs
  input wire logic       forward_start_input,
  input wire logic       reverse_start_input,
  input wire logic       panel_run_key,
  input wire logic       output_stop_input,
  input wire logic       drive_reset_input,
  input wire logic       prot_fault,
  // Watched outputs
  input wire logic       running_output,
  input wire logic [7:0] set_freq_monitor,
  input wire logic       measure_full,
  input wire logic       measure_r_only,
  input wire logic       constants_write_en,
  input wire logic       inputs_gated
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // Assertions
  a_gate_follows_run: assert property (inputs_gated == running_output)
    else $error("input gating differs from running state");
  a_setfreq_zero: assert property (running_output |-> set_freq_monitor == 8'h00)
    else $error("set frequency monitor not zero while tuning");
  // Sync chain makes three cycles the shortest start latency
  a_start_has_cause: assert property ($rose(running_output) |-> $past(forward_start_input, 3) ||
    $past(reverse_start_input, 3) || $past(panel_run_key, 3))
    else $error("tuning began without a start command");
  a_stop_aborts: assert property (running_output && $rose(output_stop_input) |-> ##[1:5] !running_output)
    else $error("output stop did not end tuning");
  a_reset_aborts: assert property (running_output && $rose(drive_reset_input) |-> ##[1:5] !running_output)
    else $error("drive reset did not end tuning");
  a_fault_ends_run: assert property (running_output && $rose(prot_fault) |-> ##[1:5] !running_output)
    else $error("protective fault did not end tuning");
  a_one_mode_runs: assert property (running_output == (measure_full ^ measure_r_only))
    else $error("measurement mode disagrees with running state");
  a_write_after_run: assert property ($rose(constants_write_en) |-> $past(running_output))
    else $error("constants written without a completed run");
  // ==========================================================
  // Covers
  c_run: cover property ($rose(running_output));
  c_done: cover property ($rose(constants_write_en));
  c_stop: cover property (running_output && $rose(output_stop_input));
endmodule
bind mct_sequencer mct_sequencer_monitor u_mon (.ref_clk(ref_clk), .rst(rst),
  .forward_start_input(forward_start_input), .reverse_start_input(reverse_start_input),
  .panel_run_key(panel_run_key), .output_stop_input(output_stop_input), .drive_reset_input(drive_reset_input),
  .prot_fault(prot_fault), .running_output(running_output), .set_freq_monitor(set_freq_monitor),
  .measure_full(measure_full), .measure_r_only(measure_r_only), .constants_write_en(constants_write_en),
  .inputs_gated(inputs_gated));

// ### dv/mct_controller.sv
// Model of the external start and stop controller
module mct_controller (
  // Clock
  input  wire logic ref_clk,
  // Terminal drives
  output logic      forward_start_input,
  output logic      reverse_start_input,
  output logic      output_stop_input,
  output logic      drive_reset_input,
  output logic      second_function_select_input,
  output logic      panel_run_key,
  output logic      panel_stop_key
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // select held still
  initial begin
    {forward_start_input, reverse_start_input, output_stop_input, drive_reset_input} = 4'h0;
    {second_function_select_input, panel_run_key, panel_stop_key} = 3'h0;
  end
  // start at rest with power on
  task automatic start(input int kind);
    @(posedge ref_clk);
    if (kind == 0) forward_start_input <= 1'b1;
    else if (kind == 1) reverse_start_input <= 1'b1;
    else panel_run_key <= 1'b1;
    // A key is a press, not a held level
    repeat (6) @(posedge ref_clk);
    panel_run_key <= 1'b0;
  endtask
  task automatic abort(input int how);
    @(posedge ref_clk);
    case (how)
      1: output_stop_input <= 1'b1;
      2: drive_reset_input <= 1'b1;
      3: {forward_start_input, reverse_start_input} <= 2'h0;
      default: press_stop();
    endcase
  endtask
  task automatic release_all(input logic panel);
    @(posedge ref_clk);
    {forward_start_input, reverse_start_input, output_stop_input, drive_reset_input} <= 4'h0;
    if (panel) press_stop();
  endtask
  task automatic press_stop;
    @(posedge ref_clk);
    panel_stop_key <= 1'b1;
    repeat (6) @(posedge ref_clk);
    panel_stop_key <= 1'b0;
  endtask
endmodule

// ### dv/test_motor_constant_tuning_sequencer.sv
// Self-checking bench of the motor constant tuning sequencer
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_motor_constant_tuning_sequencer
  import mct_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Short run lengths keep the simulation brief
  localparam longint ALL_N = 100;
  localparam longint R_N   = 40;
  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  logic        hsel    = 1'b0;
  logic        hwrite  = 1'b0;
  logic [1:0]  htrans  = 2'h0;
  logic [31:0] haddr   = 32'h0;
  logic [31:0] hwdata  = 32'h0;
  logic        vf      = 1'b0;
  logic [3:0]  flt     = 4'h0;
  logic [7:0]  spd     = 8'h0;
  logic [7:0]  cur     = 8'h0;
  logic [7:0]  mon_exp = 8'h0;
  logic [31:0] hrdata, q;
  logic        hready, hresp, fwd, rev, ostop, dres, sfs, prun, pstop;
  logic        run, mfull, mr, cwe, gated, irq;
  logic [7:0]  amon, sfm;
  int          n_mismatch = 0;
  int          checked    = 0;
  int          cnt, kd;
  always #5 ref_clk = ~ref_clk;
  mct_sequencer #(.ALL_CYCLES(ALL_N), .R_CYCLES(R_N)) u_mct_sequencer (
    .ref_clk(ref_clk), .rst(rst), .clk_en(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .forward_start_input(fwd), .reverse_start_input(rev), .output_stop_input(ostop), .drive_reset_input(dres),
    .vf_switch_input(vf), .second_function_select_input(sfs), .panel_run_key(prun), .panel_stop_key(pstop),
    .prot_fault(flt[0]), .stall_fault(flt[1]), .volt_fault(flt[2]), .calc_fault(flt[3]), .speed_monitor(spd),
    .current_monitor(cur), .running_output(run), .analog_monitor_output(amon), .set_freq_monitor(sfm),
    .measure_full(mfull), .measure_r_only(mr), .constants_write_en(cwe), .inputs_gated(gated), .irq(irq));
  mct_controller u_mct_controller (.ref_clk(ref_clk), .forward_start_input(fwd), .reverse_start_input(rev),
    .output_stop_input(ostop), .drive_reset_input(dres), .second_function_select_input(sfs),
    .panel_run_key(prun), .panel_stop_key(pstop));
  // ==========================================================
  // Bus and expectation helpers
  // Read data is taken at the edge that ends the data phase
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
    @(posedge ref_clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    `CHK(q, e)
    `CHK(hresp, 1'b0)
  endtask
  function automatic logic [7:0] exp_code(input int how);
    case (how)
      5: return TS_PROT;
      6: return TS_STALL;
      7: return TS_VOLT;
      8: return TS_CALC;
      default: return TS_FORCED;
    endcase
  endfunction
  task automatic print_verdict;
    if (n_mismatch == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========================================================
  // One tuning run: how 0 ends normally, 1-4 abort, 5-8 fault
  task automatic tune(input logic [7:0] set, input int how, input int kind, input logic v);
    longint n;
    n = (set == TS_ALL) ? ALL_N : R_N;
    @(posedge ref_clk);
    vf <= v;
    bus(OFS_CTRL, 1'b1, {28'h0, (how == 0) ? MONSEL_CURR : 2'(how % 2), kind == 2, ~v});
    bus(OFS_TUNE, 1'b1, {24'h0, set});
    bus(OFS_IMASK, 1'b1, 32'hf);
    bus(OFS_ISTAT, 1'b0, 32'h0);
    cur <= 8'($urandom);
    spd <= 8'($urandom);
    u_mct_controller.start(kind);
    @(negedge ref_clk);
    `CHK(run, 1'b1)
    `CHK(sfm, 8'h00)
    // Three cycles of the run have passed here; progress is linear over the run
    if (how == 0) `CHK(amon, cur)
    else `CHK(amon, 8'((3 * 256) / n))
    `CHK({mfull, mr}, (set == TS_ALL) ? 2'b10 : 2'b01)
    rd_chk(OFS_TUNE, {24'h0, set + 8'h01});
    if (how == 0) begin
      cnt = 0;
      while (run === 1'b1 && cnt < 300) begin
        @(negedge ref_clk);
        cnt++;
      end
      // About seven cycles of the run pass before counting starts
      `CHK(cnt <= n && cnt >= n - 25, 1'b1)
      `CHK(cwe, 1'b1)
      `CHK(irq, 1'b1)
      rd_chk(OFS_ISTAT, 32'h3);
      `CHK(irq, 1'b0)
      bus(OFS_TUNE, 1'b1, {24'h0, set});
      rd_chk(OFS_TUNE, {24'h0, set + 8'h02});
    end else begin
      repeat ($urandom_range(15, 2)) @(posedge ref_clk);
      if (how <= 4) u_mct_controller.abort(how);
      else flt <= 4'(4'h1 << (how - 5));
      repeat (6) @(negedge ref_clk);
      `CHK(run, 1'b0)
      `CHK(cwe, 1'b0)
      rd_chk(OFS_TUNE, {24'h0, exp_code(how)});
    end
    @(posedge ref_clk);
    flt <= 4'h0;
    u_mct_controller.release_all(kind == 2);
    repeat (12) @(negedge ref_clk);
    `CHK(sfm, mon_exp)
    `CHK(amon, (how == 0) ? cur : spd)
    bus(OFS_STAT, 1'b0, 32'h0);
    `CHK(q[1:0], ST_IDLE)
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'h4f60));
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rd_chk(OFS_MOTOR, 32'h270f270f);
    rd_chk(8'h40, 32'h0);
    bus(OFS_TUNE, 1'b1, 32'h1);
    bus(OFS_CTRL, 1'b1, 32'h1);
    u_mct_controller.start(0);
    repeat (4) @(negedge ref_clk);
    `CHK(run, 1'b0)
    u_mct_controller.release_all(1'b0);
    bus(OFS_MOTOR, 1'b1, {12'h0, 3'($urandom_range(5, 1)), 1'b0, 16'($urandom_range(550, 1))});
    mon_exp = 8'($urandom_range(255, 60));
    bus(OFS_MON, 1'b1, {24'h0, mon_exp});
    if (mon_exp > MAX_FREQ_HZ) mon_exp = MAX_FREQ_HZ;
    rd_chk(OFS_MON, {24'h0, mon_exp});
    tune(TS_ALL, 0, 0, 1'b0);
    tune(TS_R_ONLY, 0, 1, 1'b1);
    tune(TS_ALL, 0, 2, 1'b0);
    for (int h = 1; h <= 8; h++) begin
      kd = (h == 4) ? 2 : (h == 3) ? $urandom_range(1, 0) : $urandom_range(2, 0);
      tune(($urandom_range(1, 0) != 0) ? TS_ALL : TS_R_ONLY, h, kd, 1'b0);
    end
    print_verdict;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    print_verdict;
  end
endmodule
